// ==== dv/rms_ref_src.sv ====
// far-side reference source: a word-clock-like square wave and an error level
// assumes the bench enables it and passes the device's port enable back in
`timescale 1ns/1ps
module rms_ref_src
(
   // control
   input wire logic run,
   input wire logic err,
   input wire logic dev_oe,
   // reference line
   output logic ref_o,
   output logic ref_err
);
   // ==========================================
   // 800 ns period, phase unrelated to the system clock
   initial
   begin
      ref_o = 1'b0;
      #37;
      forever
      begin
         #400;
         // quiet while the device drives the port: no master against a live source
         ref_o <= (run && !dev_oe) ? ~ref_o : 1'b0;
      end
   end
   assign ref_err = err;
endmodule

// ==== dv/tb_top.sv ====
// self-checking bench for the reference-mode clock select block
// assumes the design files under verilog/ and the reference source model
`timescale 1ns/1ps
module tb_top;
   import rms_pkg::*;
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_total++; $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
   logic sys_clk, rstn, cyc, stb, we, ack, ref_o, ref_oe, term, tick, fb, irq, run, err, src, src_err;
   logic [3:0] adr, sel;
   logic [31:0] wdat, rdat, q, n;
   rms_pair_t p12, p34;
   rms_pair_t [COPIES-1:0] o12, o34;
   int err_total = 0;
   int compares = 0;
   wire ref_pin = ref_oe ? ref_o : src;
   logic [DIV_W-1:0] divs [4] = '{DIV_44K1, DIV_48K, DIV_88K2, DIV_96K};
   rms_ref_src src_u (.run(run), .err(err), .dev_oe(ref_oe), .ref_o(src), .ref_err(src_err));
   rms_clock_select dut_u (.SYS_CLK(sys_clk), .RSTN(rstn), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
      .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_SEL_I(sel), .WB_DAT_O(rdat), .WB_ACK_O(ack), .REF_I(ref_pin),
      .REF_ERR_I(src_err), .REF_O(ref_o), .REF_OE(ref_oe), .REF_TERM_EN(term), .PAIR12_IN(p12),
      .PAIR34_IN(p34), .PAIR12_OUT(o12), .PAIR34_OUT(o34), .SAMPLE_TICK(tick), .FALLBACK_ACTIVE(fb), .IRQ(irq));
   // ==========================================
   // clock and watchdog
   initial
   begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   initial
   begin
      #3_000_000;
      err_total++;
      stop_test();
   end
   // ==========================================
   // helpers
   task automatic stop_test();
      if (err_total == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int k;
      @(posedge sys_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      k = 0;
      do begin @(posedge sys_clk); k++; end while (ack !== 1'b1 && k < 50);
      // a slave that never answers counts as a mismatch
      if (ack !== 1'b1)
         err_total++;
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   // cycles until FALLBACK_ACTIVE shows v, at most lim
   task automatic wait_fb(input logic v, input int lim);
      n = 0;
      while (fb !== v && n < lim) begin @(posedge sys_clk); n++; end
   endtask
   // gap between two ticks; the first gap after a switch may be short
   task automatic period();
      int k;
      k = 0;
      do begin @(posedge sys_clk); k++; end while (tick !== 1'b1 && k < 400);
      n = 0;
      do begin @(posedge sys_clk); n++; end while (tick !== 1'b1 && n < 400);
   endtask
   // ==========================================
   // scenarios
   task automatic t_reset();
      `CHK(fb, 1'b1)
      `CHK({ref_oe, term}, 2'b00)
      wb(1'b0, REG_CTRL, '0);
      `CHK(q, 32'h4)
      period();
      `CHK(n, 32'(DIV_48K))
   endtask
   task automatic t_modes();
      run <= 1'b1;
      for (int r = 0; r < 4; r++)
      begin
         wb(1'b1, REG_CTRL, {27'h0, 1'b0, r[1:0], MODE_FREE});
         period();
         `CHK(n, 32'(divs[r]))
         `CHK({fb, ref_oe}, 2'b10)
      end
      wb(1'b1, REG_CTRL, {27'h0, 1'b1, RATE_48K, MODE_MASTER});
      period();
      `CHK(n, 32'(DIV_48K))
      `CHK({fb, ref_oe, term}, 3'b110)
      // master output is a square wave: div_top>>1 cycles of each fallback period high, half of the 48k period
      n = 0;
      repeat (DIV_48K)
      begin
         @(posedge sys_clk);
         n = n + 32'(ref_o);
      end
      `CHK(n, 32'(DIV_48K / 2))
      wb(1'b1, REG_CTRL, {27'h0, 1'b0, RATE_96K, MODE_ILLEGAL});
      wb(1'b0, REG_CTRL, '0);
      `CHK(q, 32'hd)
      wb(1'b0, 4'h2, '0);
      `CHK(q, 32'h0)
   endtask
   task automatic t_follow();
      // installer picks the common rate for the fallback
      wb(1'b1, REG_CTRL, {27'h0, 1'b1, RATE_48K, MODE_SLAVE});
      // port pins are registered from the new setting one edge after the write
      @(posedge sys_clk);
      `CHK({ref_oe, term}, 2'b01)
      wb(1'b1, REG_IRQ_MASK, 32'h7);
      wait_fb(1'b0, 200);
      `CHK(fb, 1'b0)
      period();
      `CHK(n, 32'h8)
      for (int i = 0; i < COPIES; i++)
      begin
         `CHK({o12[i], o34[i]}, {p12, p34})
      end
      wb(1'b0, REG_STATUS, '0);
      `CHK(q[1:0], 2'b10)
      `CHK(irq, 1'b1)
      wb(1'b1, REG_IRQ_STAT, 32'h7);
      wb(1'b0, REG_IRQ_STAT, '0);
      `CHK({q, irq}, 33'h0)
   endtask
   task automatic t_error();
      err <= 1'b1;
      wait_fb(1'b1, 10);
      `CHK(fb, 1'b1)
      period();
      `CHK(n, 32'(DIV_48K))
      wb(1'b0, REG_IRQ_STAT, '0);
      `CHK({q[2:0], irq}, 4'b1011)
      err <= 1'b0;
      wait_fb(1'b0, 200);
      `CHK(fb, 1'b0)
      run <= 1'b0;
      wait_fb(1'b1, 500);
      `CHK(n >= 380 && n <= 410, 1'b1)
      period();
      `CHK(n, 32'(DIV_48K))
   endtask
   // ==========================================
   // main sequence
   initial
   begin
      rstn = 1'b0;
      {cyc, stb, we, run, err} = '0;
      adr = '0;
      sel = 4'hf;
      wdat = '0;
      p12 = {24'h123456, 24'h654321};
      p34 = {24'habcdef, 24'hfedcba};
      repeat (3) @(posedge sys_clk);
      rstn <= 1'b1;
      t_reset();
      t_modes();
      t_follow();
      t_error();
      stop_test();
   end
endmodule

// ==== verilog/rms_clock_select.sv ====
// reference-mode clock select: sample-clock source, reference port direction, fallback rate
// assumes audio pairs come from logic on SYS_CLK; reference pins are asynchronous
//
// Implementation choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
module rms_clock_select
(
   // system
   input wire logic SYS_CLK,
   input wire logic RSTN,
   // wishbone slave
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [rms_pkg::ADR_W-1:0] WB_ADR_I,
   input wire logic [31:0] WB_DAT_I,
   input wire logic [3:0] WB_SEL_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   // reference port
   input wire logic REF_I,
   input wire logic REF_ERR_I,
   output logic REF_O,
   output logic REF_OE,
   output logic REF_TERM_EN,
   // audio
   input wire rms_pkg::rms_pair_t PAIR12_IN,
   input wire rms_pkg::rms_pair_t PAIR34_IN,
   output rms_pkg::rms_pair_t [rms_pkg::COPIES-1:0] PAIR12_OUT,
   output rms_pkg::rms_pair_t [rms_pkg::COPIES-1:0] PAIR34_OUT,
   output logic SAMPLE_TICK,
   // status and interrupt
   output logic FALLBACK_ACTIVE,
   output logic IRQ
);
   import rms_pkg::*;

   // ==========================================================
   // state
   rms_ctrl_t ctrl;
   rms_irq_t irq_stat;
   rms_irq_t irq_mask;
   rms_sync_t sync_state;
   rms_sync_t next_sync;
   logic ref_meta;
   logic ref_sync;
   logic ref_prev;
   logic err_meta;
   logic err_sync;
   logic err_prev;
   logic [LOSS_W-1:0] loss_cnt;
   logic [EDGE_W-1:0] edge_cnt;
   logic [DIV_W-1:0] div_cnt;

   // ==========================================================
   // pin synchronisers; first stage feeds only the second
   always_ff @(posedge SYS_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         ref_meta <= 1'b0;
         ref_sync <= 1'b0;
         ref_prev <= 1'b0;
         err_meta <= 1'b0;
         err_sync <= 1'b0;
         err_prev <= 1'b0;
      end
      else
      begin
         ref_meta <= REF_I;
         ref_sync <= ref_meta;
         ref_prev <= ref_sync;
         err_meta <= REF_ERR_I;
         err_sync <= err_meta;
         err_prev <= err_sync;
      end
   end

   // ==========================================================
   // decode
   wire mode_slave = (ctrl.mode == MODE_SLAVE);
   wire mode_master = (ctrl.mode == MODE_MASTER);
   // reference edges only count in slave mode
   wire ref_rise = mode_slave & ref_sync & ~ref_prev;
   wire ref_err = mode_slave & err_sync;
   wire ref_lost = (loss_cnt == LOSS_CYC);
   wire following = (sync_state == SYNC_FOLLOW);
   wire [DIV_W-1:0] div_top = (ctrl.rate == RATE_44K1) ? DIV_44K1 :
                              (ctrl.rate == RATE_48K) ? DIV_48K :
                              (ctrl.rate == RATE_88K2) ? DIV_88K2 : DIV_96K;
   wire div_end = (div_cnt >= div_top - 1'b1);
   // divider runs free so a fallback tick is never more than one period away
   // a mode write leaves the follow state a cycle late; the fallback must still tick then
   wire next_tick = (following && mode_slave) ? ref_rise : div_end;
   wire ref_half = (div_cnt < (div_top >> 1));

   // ==========================================================
   // sync source selection
   always_comb
   begin
      next_sync = sync_state;
      unique case (sync_state)
         SYNC_INTERNAL:
         begin
            if (ref_rise && !ref_err)
               next_sync = SYNC_LOCKING;
         end
         SYNC_LOCKING:
         begin
            if (!mode_slave || ref_err || ref_lost)
               next_sync = SYNC_INTERNAL;
            else if (ref_rise && edge_cnt == LOCK_EDGES - 1'b1)
               next_sync = SYNC_FOLLOW;
         end
         SYNC_FOLLOW:
         begin
            if (!mode_slave || ref_err || ref_lost)
               next_sync = SYNC_INTERNAL;
         end
         default:
            next_sync = SYNC_INTERNAL;
      endcase
   end

   always_ff @(posedge SYS_CLK or negedge RSTN)
   begin
      if (!RSTN)
         sync_state <= SYNC_INTERNAL;
      else
         sync_state <= next_sync;
   end

   // ==========================================================
   // reference presence, lock count, fallback divider
   wire [LOSS_W-1:0] next_loss = (ref_rise) ? '0 : (ref_lost || !mode_slave) ? LOSS_CYC : loss_cnt + 1'b1;
   wire [EDGE_W-1:0] next_edge = (sync_state != SYNC_LOCKING) ? '0 : ref_rise ? edge_cnt + 1'b1 : edge_cnt;
   wire [DIV_W-1:0] next_div = div_end ? '0 : div_cnt + 1'b1;

   always_ff @(posedge SYS_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         loss_cnt <= LOSS_CYC;
         edge_cnt <= '0;
         div_cnt <= '0;
      end
      else
      begin
         loss_cnt <= next_loss;
         edge_cnt <= next_edge;
         div_cnt <= next_div;
      end
   end

   // ==========================================================
   // wishbone register file, one wait state
   wire wb_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
   wire wb_wr = wb_req & WB_WE_I & WB_SEL_I[0];
   wire hit_ctrl = (WB_ADR_I == REG_CTRL);
   wire hit_status = (WB_ADR_I == REG_STATUS);
   wire hit_stat = (WB_ADR_I == REG_IRQ_STAT);
   wire hit_mask = (WB_ADR_I == REG_IRQ_MASK);
   wire rms_ctrl_t wr_ctrl = rms_ctrl_t'(WB_DAT_I[$bits(rms_ctrl_t)-1:0]);
   // the unused mode code is refused and the old mode kept
   wire rms_mode_t wr_mode = (WB_DAT_I[1:0] == MODE_ILLEGAL) ? ctrl.mode : wr_ctrl.mode;
   wire rms_ctrl_t next_ctrl = (wb_wr && hit_ctrl) ?
                               rms_ctrl_t'{term75: wr_ctrl.term75, rate: wr_ctrl.rate, mode: wr_mode} : ctrl;
   wire rms_status_t status = '{ref_error: ref_err, ref_present: mode_slave & ~ref_lost, locked: following,
                                fallback_active: ~following};
   wire rms_irq_t irq_evt = '{err_seen: mode_slave & err_sync & ~err_prev,
                              locked: (next_sync == SYNC_FOLLOW) & ~following,
                              fallback: following & (next_sync != SYNC_FOLLOW)};
   wire rms_irq_t irq_clr = (wb_wr && hit_stat) ? rms_irq_t'(WB_DAT_I[$bits(rms_irq_t)-1:0]) : '0;
   // a new event wins over a clear in the same cycle
   wire rms_irq_t next_stat = (irq_stat & ~irq_clr) | irq_evt;
   wire rms_irq_t next_mask = (wb_wr && hit_mask) ? rms_irq_t'(WB_DAT_I[$bits(rms_irq_t)-1:0]) : irq_mask;
   wire [31:0] rd_word = hit_ctrl ? 32'(ctrl) :
                         hit_status ? 32'(status) :
                         hit_stat ? 32'(irq_stat) :
                         hit_mask ? 32'(irq_mask) : 32'h0000_0000;

   always_ff @(posedge SYS_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         ctrl <= CTRL_RESET;
         irq_stat <= IRQ_RESET;
         irq_mask <= IRQ_RESET;
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= '0;
         IRQ <= 1'b0;
      end
      else
      begin
         ctrl <= next_ctrl;
         irq_stat <= next_stat;
         irq_mask <= next_mask;
         WB_ACK_O <= wb_req;
         WB_DAT_O <= wb_req ? rd_word : '0;
         IRQ <= |(irq_stat & irq_mask);
      end
   end

   // ==========================================================
   // reference port and sample tick
   always_ff @(posedge SYS_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         REF_OE <= 1'b0;
         REF_O <= 1'b0;
         REF_TERM_EN <= 1'b0;
         SAMPLE_TICK <= 1'b0;
         FALLBACK_ACTIVE <= 1'b1;
      end
      else
      begin
         REF_OE <= mode_master;
         REF_O <= mode_master & ref_half;
         REF_TERM_EN <= mode_slave & ctrl.term75;
         SAMPLE_TICK <= next_tick;
         FALLBACK_ACTIVE <= (next_sync != SYNC_FOLLOW);
      end
   end

   // ==========================================================
   // output copies; converter keeps running whatever the source
   for (genvar g = 0; g < COPIES; g++)
   begin : g_copy
      always_ff @(posedge SYS_CLK or negedge RSTN)
      begin
         if (!RSTN)
         begin
            PAIR12_OUT[g] <= '0;
            PAIR34_OUT[g] <= '0;
         end
         else if (next_tick)
         begin
            PAIR12_OUT[g] <= PAIR12_IN;
            PAIR34_OUT[g] <= PAIR34_IN;
         end
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (!RSTN);

   AST_SLAVE_INPUT: assert property (mode_slave |=> !REF_OE)
      else $error("reference port driven in slave mode");
   AST_FREE_IGNORES: assert property ((ctrl.mode == MODE_FREE) ##1 (ctrl.mode == MODE_FREE) |-> !following && !REF_OE)
      else $error("free-running mode reacted to the reference");
   AST_FOLLOW_TICK: assert property (following && next_sync == SYNC_FOLLOW && ref_rise |=> SAMPLE_TICK)
      else $error("reference edge gave no sample tick");
   AST_MASTER_FALLBACK: assert property (!mode_slave && div_end |=> SAMPLE_TICK && !following)
      else $error("master or free mode not on fallback rate");
   AST_LOSS_SWITCH: assert property (following && ref_lost |=> sync_state == SYNC_INTERNAL ##1 FALLBACK_ACTIVE)
      else $error("lost reference did not switch to internal");
   AST_ERR_SWITCH: assert property (following && ref_err |=> sync_state == SYNC_INTERNAL)
      else $error("reference error did not switch to fallback");
   AST_NO_MUTE: assert property ($fell(following) |-> ##[1:230] SAMPLE_TICK)
      else $error("sample ticks stopped after losing reference");
   AST_COPIES_SAME: assert property (PAIR12_OUT[0] == PAIR12_OUT[3] && PAIR34_OUT[1] == PAIR34_OUT[2])
      else $error("output copies differ");
   AST_STATUS_FLAG: assert property (FALLBACK_ACTIVE == !following)
      else $error("fallback status does not match source");
   AST_IRQ_LEVEL: assert property (|(irq_stat & irq_mask) |=> IRQ)
      else $error("interrupt not raised for unmasked status");
   AST_FREE_PORT_OFF: assert property ((ctrl.mode == MODE_FREE) |=> !REF_OE && !REF_TERM_EN)
      else $error("reference port active in free-running mode");
   AST_NOT_SLAVE_INTERNAL: assert property (!mode_slave |=> !following)
      else $error("master or free mode still following the reference");
   AST_ERR_BLOCKS_FOLLOW: assert property (ref_err |=> !following)
      else $error("following a reference that carries an error");
   AST_LOCK_NEEDS_EDGE: assert property ((next_sync == SYNC_FOLLOW) && !following |-> ref_rise)
      else $error("follow entered without a reference edge");
   AST_COPIES_REST: assert property (PAIR12_OUT[1] == PAIR12_OUT[0] && PAIR34_OUT[3] == PAIR34_OUT[0])
      else $error("output copies b or d differ");

   COV_LOCK: cover property ((sync_state == SYNC_LOCKING) ##[1:100] following);
   COV_ERR_RESUME: cover property (following ##1 !following ##[1:1000] following);
   COV_MASTER: cover property (REF_OE && REF_O);
   COV_CLEAR_RACE: cover property (wb_wr && hit_stat && |irq_evt);
   COV_MODE_LEAVES_FOLLOW: cover property (following && !mode_slave);

endmodule

// ==== verilog/rms_pkg.sv ====
// package for the reference-mode clock select block
// assumes one 10 MHz system clock and a classic wishbone register bus
package rms_pkg;

   // ==========================================================
   // clock and timing
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned CLK_PERIOD_NS = 100;
   // reference counts as absent after this long without a rising edge
   localparam int unsigned REF_LOSS_NS = 40_000;
   localparam int unsigned LOSS_W = 9;
   localparam logic [LOSS_W-1:0] LOSS_CYC = LOSS_W'(REF_LOSS_NS / CLK_PERIOD_NS);
   // consecutive clean edges needed in locking, after the edge that starts locking, before following the reference
   localparam int unsigned EDGE_W = 3;
   localparam logic [EDGE_W-1:0] LOCK_EDGES = 3'h4;

   // ==========================================================
   // fallback sample rates
   localparam int unsigned RATE_44K1_HZ = 44_100;
   localparam int unsigned RATE_48K_HZ = 48_000;
   localparam int unsigned RATE_88K2_HZ = 88_200;
   localparam int unsigned RATE_96K_HZ = 96_000;
   localparam int unsigned DIV_W = 8;
   localparam logic [DIV_W-1:0] DIV_44K1 = DIV_W'(CLK_HZ / RATE_44K1_HZ);
   localparam logic [DIV_W-1:0] DIV_48K = DIV_W'(CLK_HZ / RATE_48K_HZ);
   localparam logic [DIV_W-1:0] DIV_88K2 = DIV_W'(CLK_HZ / RATE_88K2_HZ);
   localparam logic [DIV_W-1:0] DIV_96K = DIV_W'(CLK_HZ / RATE_96K_HZ);

   typedef enum logic [1:0] {RATE_44K1 = 2'h0, RATE_48K = 2'h1, RATE_88K2 = 2'h2, RATE_96K = 2'h3} rms_rate_t;
   typedef enum logic [1:0] {MODE_SLAVE = 2'h0, MODE_MASTER = 2'h1, MODE_FREE = 2'h3} rms_mode_t;
   localparam logic [1:0] MODE_ILLEGAL = 2'h2;
   typedef enum logic [1:0] {SYNC_INTERNAL = 2'h0, SYNC_LOCKING = 2'h1, SYNC_FOLLOW = 2'h3} rms_sync_t;

   // ==========================================================
   // register map
   localparam int unsigned ADR_W = 4;
   localparam logic [ADR_W-1:0] REG_CTRL = 4'h0;
   localparam logic [ADR_W-1:0] REG_STATUS = 4'h4;
   localparam logic [ADR_W-1:0] REG_IRQ_STAT = 4'h8;
   localparam logic [ADR_W-1:0] REG_IRQ_MASK = 4'hc;

   typedef struct packed {
      logic term75;
      rms_rate_t rate;
      rms_mode_t mode;
   } rms_ctrl_t;
   localparam rms_ctrl_t CTRL_RESET = '{term75: 1'b0, rate: RATE_48K, mode: MODE_SLAVE};

   typedef struct packed {
      logic ref_error;
      logic ref_present;
      logic locked;
      logic fallback_active;
   } rms_status_t;

   typedef struct packed {
      logic err_seen;
      logic locked;
      logic fallback;
   } rms_irq_t;
   localparam rms_irq_t IRQ_RESET = '0;

   // ==========================================================
   // audio carrier
   localparam int unsigned SAMPLE_W = 24;
   localparam int unsigned COPIES = 4;
   typedef struct packed {
      logic [SAMPLE_W-1:0] left;
      logic [SAMPLE_W-1:0] right;
   } rms_pair_t;

endpackage
